// file: shared/pec_consts.svh
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH
`define PEC_EV_NC_WRITE 6'h2E
`define PEC_EV_RD_MISS 6'h31
`define PEC_EV_WR_MISS 6'h34
`define PEC_EV_RD_STALL 6'h36
`define PEC_EV_ST_STALL 6'h3B
`define PEC_EV_MUL_LOCK 6'h3B
`define PEC_MISALIGN_HIT_CLOCKS 2'h3
`define PEC_PCE_BIT 9
`define PEC_CR_RESET 32'h0000_0000
`define PEC_CR_DEFINED_MASK 32'h0000_03FF
`define PEC_COUNT_RESET 40'h00_0000_0000
`endif

// file: shared/pec_pkg.sv
`default_nettype none
package pec_pkg;
    typedef struct packed {
        logic nc_write;
        logic rd_miss;
        logic wr_miss;
        logic rd_stall;
        logic rd_misalign_hit;
        logic st_stall_em;
        logic wbuf_nonempty;
        logic mul_dep_stall;
        logic branch_taken;
    } pec_events_t;
    typedef enum logic [2:0] {
        PEC_RUN = 3'b001,
        PEC_SMM = 3'b010,
        PEC_SHUTDOWN = 3'b100
    } pec_state_t;
endpackage
`default_nettype wire

// file: verilog/pec_counters.sv
`include "pec_consts.svh"
`default_nettype none
module pec_counters
    import pec_pkg::*;
#(
    parameter int CW = 40,
    parameter int CRW = 32
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CLOCK_ENABLE,
    input wire logic BUS_CLOCK_TICK,
    input wire pec_events_t EVENTS,
    input wire logic EXTERNAL_WRITE_BUFFER_EMPTY_N,
    input wire logic [5:0] EVENT_SELECT_0,
    input wire logic [5:0] EVENT_SELECT_1,
    input wire logic MUL_INTERLOCK_SELECT,
    input wire logic CR_WRITE,
    input wire logic [CRW-1:0] CR_WRITE_DATA,
    input wire logic [1:0] PRIVILEGE_LEVEL,
    input wire logic READ_PERF_COUNTER_INSTR,
    input wire logic COUNTER_INDEX,
    input wire logic SMI_ENTER,
    input wire logic RESUME_FROM_SYSMGMT_INSTR,
    output logic [CRW-1:0] EXTENDED_CONTROL_REGISTER,
    output logic [CRW-1:0] SAVE_AREA_CR,
    output logic SYSTEM_MANAGEMENT_STATE,
    output logic SHUTDOWN,
    output logic READ_VALID,
    output logic READ_FAULT,
    output logic [CW-1:0] READ_DATA,
    output logic [CW-1:0] COUNT_0,
    output logic [CW-1:0] COUNT_1,
    output logic [1:0] COUNTER_STATUS_PINS
);
    ////////////////////////////////////////////////////////////////////////////////
    // Control path state.
    pec_state_t state;
    pec_state_t next_state;
    logic [CRW-1:0] next_cr;
    logic [CRW-1:0] next_ext_cr;
    logic [CRW-1:0] next_save;

    // Each counter owns one element of these arrays, so no flip-flop has two writers.
    logic [CW-1:0] count [2];
    logic pending [2];
    logic status_pin [2];

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded conditions.
    wire logic in_run = (state == PEC_RUN);
    wire logic in_smm = (state == PEC_SMM);
    wire logic pce = EXTENDED_CONTROL_REGISTER[`PEC_PCE_BIT];
    wire logic level_zero = (PRIVILEGE_LEVEL == 2'h0);
    wire logic read_allowed = pce || level_zero;
    wire logic read_take = READ_PERF_COUNTER_INSTR && in_run;
    wire logic cr_load = CR_WRITE && in_run;

    // Only bits outside the defined set are reserved, so the read-enable bit survives a resume.
    wire logic [CRW-1:0] reserved_mask = ~CRW'(`PEC_CR_DEFINED_MASK);
    wire logic restore_ok = (SAVE_AREA_CR & reserved_mask) == '0;
    wire logic resume_good = in_smm && RESUME_FROM_SYSMGMT_INSTR && restore_ok;
    wire logic resume_bad = in_smm && RESUME_FROM_SYSMGMT_INSTR && !restore_ok;

    ////////////////////////////////////////////////////////////////////////////////

    // Store stall counts while either buffers hold data or the pin says not empty.
    function automatic logic [1:0] event_inc(input logic [5:0] sel, input logic mul_sel, input pec_events_t e,
                                             input logic external_write_buffer_empty_n_n);
        event_inc = 2'h0;
        if (sel == `PEC_EV_MUL_LOCK && mul_sel) begin
            event_inc = {1'b0, e.mul_dep_stall && !e.branch_taken};
        end else if (sel == `PEC_EV_NC_WRITE) begin
            event_inc = {1'b0, e.nc_write};
        end else if (sel == `PEC_EV_ST_STALL) begin
            event_inc = {1'b0, e.st_stall_em && (e.wbuf_nonempty || external_write_buffer_empty_n_n)};
        end else if (sel == `PEC_EV_RD_MISS) begin
            event_inc = {1'b0, e.rd_miss};
        end else if (sel == `PEC_EV_WR_MISS) begin
            event_inc = {1'b0, e.wr_miss};
        end else if (sel == `PEC_EV_RD_STALL) begin
            event_inc = e.rd_misalign_hit ? `PEC_MISALIGN_HIT_CLOCKS : {1'b0, e.rd_stall};
        end
    endfunction

    wire logic [1:0] inc0 = event_inc(EVENT_SELECT_0, MUL_INTERLOCK_SELECT, EVENTS, EXTERNAL_WRITE_BUFFER_EMPTY_N);
    wire logic [1:0] inc1 = event_inc(EVENT_SELECT_1, MUL_INTERLOCK_SELECT, EVENTS, EXTERNAL_WRITE_BUFFER_EMPTY_N);
    wire logic [1:0] incs [2];
    assign incs[0] = inc0;
    assign incs[1] = inc1;
    assign next_cr = cr_load ? CR_WRITE_DATA : EXTENDED_CONTROL_REGISTER;
    assign COUNT_0 = count[0];
    assign COUNT_1 = count[1];
    assign SYSTEM_MANAGEMENT_STATE = in_smm;
    assign SHUTDOWN = (state == PEC_SHUTDOWN);

    ////////////////////////////////////////////////////////////////////////////////
    // Pins only move on bus ticks, so increments are banked until the next tick.
    // The bank holds one toggle; a faster burst is a known limitation of the pins only.
    for (genvar i = 0; i < 2; i++) begin : g_ctr
        wire logic [2:0] sum = {2'h0, pending[i]} + {1'b0, incs[i]};
        wire logic have_inc = (sum != 3'h0);
        wire logic fire = BUS_CLOCK_TICK && have_inc;
        wire logic next_pending = fire ? (sum > 3'h1) : (pending[i] || have_inc);
        wire logic next_pin = fire ? ~status_pin[i] : status_pin[i];
        wire logic [CW-1:0] next_count = count[i] + CW'(incs[i]);

        always_ff @(posedge CLOCK) begin
            if (RESET) begin
                count[i] <= CW'(`PEC_COUNT_RESET);
                pending[i] <= 1'b0;
                status_pin[i] <= 1'b0;
            end else if (CLOCK_ENABLE) begin
                count[i] <= next_count;
                pending[i] <= next_pending;
                status_pin[i] <= next_pin;
            end
        end
    end

    assign COUNTER_STATUS_PINS = {status_pin[1], status_pin[0]};

    ////////////////////////////////////////////////////////////////////////////////
    // Control register, save area and run state.
    always_comb begin
        next_state = state;
        next_ext_cr = EXTENDED_CONTROL_REGISTER;
        next_save = SAVE_AREA_CR;
        case (state)
            PEC_RUN: begin
                next_ext_cr = next_cr;
                if (SMI_ENTER) begin
                    next_save = next_cr;
                    next_state = PEC_SMM;
                end
            end
            PEC_SMM: begin
                if (resume_good) begin
                    next_ext_cr = SAVE_AREA_CR;
                    next_state = PEC_RUN;
                end else if (resume_bad) begin
                    next_state = PEC_SHUTDOWN;
                end
            end
            PEC_SHUTDOWN: begin
                next_state = PEC_SHUTDOWN;
            end
            default: begin
                next_state = PEC_RUN;
            end
        endcase
    end

    // Shutdown is left only through reset, as a real core would need one.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state <= PEC_RUN;
            EXTENDED_CONTROL_REGISTER <= CRW'(`PEC_CR_RESET);
            SAVE_AREA_CR <= CRW'(`PEC_CR_RESET);
        end else if (CLOCK_ENABLE) begin
            state <= next_state;
            EXTENDED_CONTROL_REGISTER <= next_ext_cr;
            SAVE_AREA_CR <= next_save;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter reads; the data holds until the next allowed read.
    wire logic next_read_valid = read_take && read_allowed;
    wire logic next_read_fault = read_take && !read_allowed;
    wire logic [CW-1:0] next_read_data = next_read_valid ? count[COUNTER_INDEX] : READ_DATA;

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            READ_VALID <= 1'b0;
            READ_FAULT <= 1'b0;
            READ_DATA <= CW'(`PEC_COUNT_RESET);
        end else if (CLOCK_ENABLE) begin
            READ_VALID <= next_read_valid;
            READ_FAULT <= next_read_fault;
            READ_DATA <= next_read_data;
        end
    end
endmodule
`default_nettype wire

// file: test/pec_counters_asserts.sv
`include "pec_consts.svh"
`default_nettype none
module pec_counters_chk
    import pec_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic CLOCK_ENABLE,
    input wire pec_events_t EVENTS,
    input wire logic EXTERNAL_WRITE_BUFFER_EMPTY_N,
    input wire logic [5:0] EVENT_SELECT_0,
    input wire logic MUL_INTERLOCK_SELECT,
    input wire logic [1:0] PRIVILEGE_LEVEL,
    input wire logic READ_PERF_COUNTER_INSTR,
    input wire logic SMI_ENTER,
    input wire logic RESUME_FROM_SYSMGMT_INSTR,
    input wire logic CR_WRITE,
    input wire logic [31:0] CR_WRITE_DATA,
    input wire logic [31:0] EXTENDED_CONTROL_REGISTER,
    input wire logic [31:0] SAVE_AREA_CR,
    input wire logic SYSTEM_MANAGEMENT_STATE,
    input wire logic SHUTDOWN,
    input wire logic READ_VALID,
    input wire logic READ_FAULT,
    input wire logic [39:0] COUNT_0
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // Reads and control loads are only honoured in the run state.
    wire logic run = CLOCK_ENABLE && !SYSTEM_MANAGEMENT_STATE && !SHUTDOWN;
    wire logic rd_any = READ_PERF_COUNTER_INSTR && run && EXTENDED_CONTROL_REGISTER[`PEC_PCE_BIT];
    wire logic rd_priv = READ_PERF_COUNTER_INSTR && run && !EXTENDED_CONTROL_REGISTER[`PEC_PCE_BIT];
    wire logic [5:0] s = EVENT_SELECT_0;
    // A load in the entry cycle is part of what gets saved.
    wire logic [31:0] cr_in = CR_WRITE ? CR_WRITE_DATA : EXTENDED_CONTROL_REGISTER;
    pce_read_a: assert property (rd_any |=> READ_VALID && !READ_FAULT)
        else $error("read refused");
    priv_fault_a: assert property (rd_priv && PRIVILEGE_LEVEL != 2'h0 |=> READ_FAULT && !READ_VALID)
        else $error("read allowed");
    smi_save_a: assert property (SMI_ENTER && run |=> SYSTEM_MANAGEMENT_STATE && SAVE_AREA_CR == $past(cr_in))
        else $error("save wrong");
    resume_ok_a: assert property (RESUME_FROM_SYSMGMT_INSTR && CLOCK_ENABLE && SYSTEM_MANAGEMENT_STATE &&
        (SAVE_AREA_CR & ~`PEC_CR_DEFINED_MASK) == 32'h0 |=>
        !SHUTDOWN && EXTENDED_CONTROL_REGISTER == $past(SAVE_AREA_CR))
        else $error("resume wrong");
    nc_write_a: assert property (CLOCK_ENABLE && s == `PEC_EV_NC_WRITE && EVENTS.nc_write |=>
        COUNT_0 == $past(COUNT_0) + 40'h1)
        else $error("write count");
    st_stall_a: assert property (CLOCK_ENABLE && s == `PEC_EV_ST_STALL && !MUL_INTERLOCK_SELECT && EVENTS.st_stall_em &&
        (EVENTS.wbuf_nonempty || EXTERNAL_WRITE_BUFFER_EMPTY_N) |=> COUNT_0 == $past(COUNT_0) + 40'h1)
        else $error("stall count");
    misalign_a: assert property (CLOCK_ENABLE && s == `PEC_EV_RD_STALL && EVENTS.rd_misalign_hit |=>
        COUNT_0 == $past(COUNT_0) + 40'h3)
        else $error("misalign count");
    mul_idle_a: assert property (s == `PEC_EV_MUL_LOCK && MUL_INTERLOCK_SELECT && !EVENTS.mul_dep_stall |=> $stable(COUNT_0))
        else $error("interlock count");
    cover property (READ_VALID);
    cover property (READ_FAULT);
    cover property (SYSTEM_MANAGEMENT_STATE ##1 !SYSTEM_MANAGEMENT_STATE);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pec_counters pec_counters_chk u_chk(.*);
`default_nettype wire

// file: test/tb_pec_counters.sv
`default_nettype none
module tb_pec_counters import pec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK = 0, RESET = 1, ewn = 0, mul = 0, ce = 1, tick = 1;
    logic [1:0] pins;
    logic [39:0] c1;
    logic [3:0] ctl = 0;
    logic [31:0] crd = 0, cr, sav;
    logic [5:0] sel = 0;
    pec_events_t ev = '0;
    logic sms, sd, rv, rf;
    logic [39:0] rdat, c0;
    int fails = 0, cmp_count = 0;
    pec_counters u_dut(.CLOCK(CLOCK), .RESET(RESET), .CLOCK_ENABLE(ce), .BUS_CLOCK_TICK(tick), .EVENTS(ev),
        .EXTERNAL_WRITE_BUFFER_EMPTY_N(ewn), .EVENT_SELECT_0(sel), .EVENT_SELECT_1(6'h2E), .MUL_INTERLOCK_SELECT(mul),
        .CR_WRITE(ctl[3]), .CR_WRITE_DATA(crd), .PRIVILEGE_LEVEL(2'h3), .READ_PERF_COUNTER_INSTR(ctl[0]),
        .COUNTER_INDEX(1'b0), .SMI_ENTER(ctl[1]), .RESUME_FROM_SYSMGMT_INSTR(ctl[2]), .EXTENDED_CONTROL_REGISTER(cr),
        .SAVE_AREA_CR(sav), .SYSTEM_MANAGEMENT_STATE(sms), .SHUTDOWN(sd), .READ_VALID(rv), .READ_FAULT(rf),
        .READ_DATA(rdat), .COUNT_0(c0), .COUNT_1(c1), .COUNTER_STATUS_PINS(pins));
    initial forever #20 CLOCK = ~CLOCK;
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Events are held for n whole cycles, so each one is sampled exactly n times.
    task automatic evs(input logic [5:0] s, input pec_events_t e, input int n, input logic [39:0] exp);
        @(posedge CLOCK);
        sel <= s;
        ev <= e;
        repeat (n) @(posedge CLOCK);
        ev <= '0;
        @(negedge CLOCK);
        chk(c0, exp);
    endtask
    task automatic pulse(input logic [3:0] p, input logic [31:0] d);
        @(posedge CLOCK);
        ctl <= p;
        crd <= d;
        @(posedge CLOCK);
        ctl <= 4'h0;
        @(negedge CLOCK);
    endtask
    task automatic print_verdict;
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge CLOCK);
        RESET <= 0;
        @(negedge CLOCK);
        chk(c0, 40'h0);
        evs(6'h2E, '{nc_write: 1'b1, default: 1'b0}, 3, 40'h3);
        chk(pins, 2'h3);
        @(posedge CLOCK);
        tick <= 0;
        evs(6'h2E, '{nc_write: 1'b1, default: 1'b0}, 2, 40'h5);
        chk(pins, 2'h3);
        @(posedge CLOCK);
        tick <= 1;
        @(posedge CLOCK);
        @(negedge CLOCK);
        chk(pins, 2'h0);
        evs(6'h36, '{rd_stall: 1'b1, rd_misalign_hit: 1'b1, default: 1'b0}, 1, 40'h8);
        evs(6'h36, '{rd_stall: 1'b1, default: 1'b0}, 2, 40'hA);
        evs(6'h3B, '{st_stall_em: 1'b1, wbuf_nonempty: 1'b1, default: 1'b0}, 2, 40'hC);
        evs(6'h3B, '{st_stall_em: 1'b1, default: 1'b0}, 2, 40'hC);
        @(posedge CLOCK);
        ewn <= 1;
        evs(6'h3B, '{st_stall_em: 1'b1, default: 1'b0}, 1, 40'hD);
        @(posedge CLOCK);
        ewn <= 0;
        ce <= 0;
        evs(6'h31, '{rd_miss: 1'b1, default: 1'b0}, 2, 40'hD);
        @(posedge CLOCK);
        ce <= 1;
        evs(6'h31, '{rd_miss: 1'b1, default: 1'b0}, 1, 40'hE);
        @(posedge CLOCK);
        mul <= 1;
        evs(6'h3B, '{mul_dep_stall: 1'b1, branch_taken: 1'b1, default: 1'b0}, 2, 40'hE);
        evs(6'h3B, '{mul_dep_stall: 1'b1, default: 1'b0}, 2, 40'h10);
        chk(c1, 40'h5);
        pulse(4'h1, 32'h0);
        chk(rf, 1'b1);
        pulse(4'h8, 32'h0000_0200);
        pulse(4'h1, 32'h0);
        chk(rv, 1'b1);
        chk(rdat, 40'h10);
        pulse(4'h2, 32'h0);
        chk(sav, 32'h0000_0200);
        pulse(4'h4, 32'h0);
        chk({sd, sms}, 2'h0);
        chk(cr, 32'h0000_0200);
        pulse(4'h8, 32'h0000_0400);
        pulse(4'h2, 32'h0);
        chk(sav, 32'h0000_0400);
        pulse(4'h1, 32'h0);
        chk({rv, rf}, 2'h0);
        pulse(4'h4, 32'h0);
        chk({sd, sms}, 2'h2);
        @(posedge CLOCK);
        RESET <= 1;
        repeat (3) @(posedge CLOCK);
        RESET <= 0;
        @(negedge CLOCK);
        chk({sd, sms}, 2'h0);
        chk(cr, 32'h0);
        chk(c0, 40'h0);
        print_verdict;
    end
    initial begin
        repeat (300) @(posedge CLOCK);
        fails++;
        print_verdict;
    end
endmodule
`default_nettype wire
